// ===== hdl/regctl_pkg.sv
// shared constants for the two-wire register access link
package regctl_pkg;
  // ********************************
  // control byte layout
  // ********************************
  localparam logic [3:0] CTRL_CODE_RESET = 4'h0;   // control code after reset
  localparam int CTRL_CODE_MSB = 7;
  localparam int CTRL_CODE_LSB = 4;
  localparam int BLOCK_MSB = 3;
  localparam int BLOCK_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // ********************************
  // register map
  // ********************************
  localparam int PTR_W = 11;
  localparam logic [10:0] REGULATOR_OUTPUT_CONTROL_OFS = 11'h0f4;
  localparam int REGULATOR_BIT = 0;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
  localparam int MEM_DEPTH = 256;
  // ********************************
  // controller register offsets (axi4-lite byte addresses)
  // ********************************
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] ADDR_OFS = 4'h4;
  localparam logic [3:0] WDATA_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hc;
  localparam int CLK_DIV = 16;                     // ref cycles per half link period
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== hdl/regctl_link_if.sv
// two-wire link between the bus controller and the register target
`timescale 1ns/1ps
interface regctl_link_if;
  logic link_clk;
  logic data_ctl_out;
  logic data_ctl_oe_n;
  logic data_tgt_out;
  logic data_tgt_oe_n;
  logic data_line;
  // open drain wire: low when either end enables its driver
  assign data_line = ~((~data_ctl_oe_n & ~data_ctl_out) | (~data_tgt_oe_n & ~data_tgt_out));
  modport controller (output link_clk, output data_ctl_out, output data_ctl_oe_n,
    input data_line);
  modport target (input link_clk, output data_tgt_out, output data_tgt_oe_n,
    input data_line);
endinterface

// ===== hdl/sync2.sv
// two flop level synchroniser
`timescale 1ns/1ps
module sync2 #(parameter logic INIT = 1'b1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      dout <= INIT;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // sync2

// ===== hdl/regctl_target.sv
// register target: device end of the two-wire link
`timescale 1ns/1ps
module regctl_target import regctl_pkg::*; (
  input wire logic SYS_RST,
  input wire logic [3:0] CTRL_CODE,
  regctl_link_if.target LINK,
  output logic REGULATOR_CONTROL_OUTPUT
);
  typedef enum logic [2:0] {IDLE, CTRL, WADDR, WDATA, RDATA, ACK, SKIP} state_type;
  // ********************************
  // start detect
  // ********************************
  logic clk;
  logic sda_d;
  logic start_d;
  logic start_tog_q;
  logic start_seen_q;
  assign clk = LINK.link_clk;
  assign sda_d = LINK.data_line;
  // a data fall while the clock is high is a start; no clock edge comes
  // between stop and the next start, so the data line clocks this flop
  always_ff @(negedge LINK.data_line or posedge SYS_RST) begin
    if (SYS_RST) start_tog_q <= 1'b0;
    else if (clk) start_tog_q <= ~start_tog_q;
  end
  // first rising clock edge after a start sees the toggle as new
  always_ff @(posedge clk or posedge SYS_RST) begin
    if (SYS_RST) start_seen_q <= 1'b0;
    else start_seen_q <= start_tog_q;
  end
  assign start_d = start_tog_q ^ start_seen_q;
  // ********************************
  // byte engine
  // ********************************
  state_type state_q;
  state_type after_ack_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [10:0] ptr_q;
  logic [2:0] block_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic ack_drive_q;
  logic rd_drive_q;
  logic [7:0] rd_byte_q;
  // each bit is taken on the rising edge; the data line drive changes on the falling edge
  // link clock stands still in reset, so reset acts without it
  always_ff @(posedge clk or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= IDLE;
      bit_q <= 3'h7;
      shift_q <= 8'h00;
      ptr_q <= '0;
      block_q <= 3'h0;
      after_ack_q <= IDLE;
      for (int i = 0; i < MEM_DEPTH; i++) mem_q[i] <= 8'h00;
      mem_q[REGULATOR_OUTPUT_CONTROL_OFS[7:0]] <= REGULATOR_CONTROL_RESET;
    end else if (start_d) begin
      // this edge already carries the first control bit
      state_q <= CTRL;
      shift_q <= {7'h00, sda_d};
      bit_q <= 3'h6;
    end else begin
      unique case (state_q)
        IDLE, SKIP: ;
        ACK: begin
          state_q <= after_ack_q;
          bit_q <= 3'h7;
        end
        RDATA: begin
          if (bit_q == 3'h0) state_q <= SKIP; // single byte; master nacks
          else bit_q <= bit_q - 3'h1;
        end
        CTRL, WADDR, WDATA: begin
          shift_q <= {shift_q[6:0], sda_d};
          if (bit_q != 3'h0) begin
            bit_q <= bit_q - 3'h1;
          end else if (state_q == CTRL) begin
            if ({shift_q[6:3]} == CTRL_CODE) begin
              state_q <= ACK;
              block_q <= shift_q[2:0];
              after_ack_q <= (sda_d == DIR_READ) ? RDATA : WADDR;
            end else begin
              state_q <= SKIP;
            end
          end else if (state_q == WADDR) begin
            ptr_q <= {block_q, shift_q[6:0], sda_d};
            state_q <= ACK;
            after_ack_q <= WDATA;
          end else begin
            // commit as the acknowledge goes out
            if (ptr_q[10:8] == REGULATOR_OUTPUT_CONTROL_OFS[10:8]) begin
              mem_q[ptr_q[7:0]] <= {shift_q[6:0], sda_d};
            end
            state_q <= ACK;
            after_ack_q <= SKIP;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end
  // ********************************
  // data line drive on the falling edge
  // ********************************
  always_ff @(negedge clk or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_drive_q <= 1'b0;
      rd_drive_q <= 1'b0;
      rd_byte_q <= 8'hff;
    end else begin
      ack_drive_q <= (state_q == ACK);
      rd_drive_q <= (state_q == RDATA) & ~rd_byte_q[7];
      if (state_q == ACK && after_ack_q == RDATA) begin
        rd_byte_q <= (ptr_q[10:8] == 3'h0) ? mem_q[ptr_q[7:0]] : 8'hff;
      end else if (state_q == RDATA) begin
        rd_byte_q <= {rd_byte_q[6:0], 1'b1};
      end
    end
  end
  logic drive_low;
  assign drive_low = ack_drive_q | (rd_drive_q);
  assign LINK.data_tgt_out = 1'b0;
  assign LINK.data_tgt_oe_n = ~drive_low;
  // ********************************
  // regulator output
  // ********************************
  always_ff @(posedge clk or posedge SYS_RST) begin
    if (SYS_RST) REGULATOR_CONTROL_OUTPUT <= REGULATOR_CONTROL_RESET[REGULATOR_BIT];
    else REGULATOR_CONTROL_OUTPUT <= mem_q[REGULATOR_OUTPUT_CONTROL_OFS[7:0]][REGULATOR_BIT];
  end
endmodule // regctl_target

// ===== hdl/regctl_controller.sv
// bus controller end: axi4-lite registers drive byte write and random read
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module regctl_controller import regctl_pkg::*; (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  regctl_link_if.controller LINK,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  typedef enum logic [1:0] {L_IDLE, L_START, L_BITS} lstate_type;
  // ********************************
  // register file
  // ********************************
  logic [10:0] addr_q;
  logic [7:0] wdat_q;
  logic [3:0] code_q;
  logic go_q;
  logic rd_q;
  logic busy_q;
  logic nack_q;
  logic [7:0] rdat_q;
  logic aw_q;
  logic w_q;
  logic [3:0] awa_q;
  logic [31:0] wd_q;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= AXI_OKAY;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      addr_q <= 11'h0;
      wdat_q <= 8'h00;
      code_q <= CTRL_CODE_RESET;
      go_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (AWVALID && AWREADY) begin
        aw_q <= 1'b1;
        awa_q <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_q <= 1'b1;
        wd_q <= WDATA;
        WREADY <= 1'b0;
      end
      if (aw_q && w_q && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= AXI_OKAY;
        unique case (awa_q)
          CMD_OFS: begin
            if (!busy_q) begin
              go_q <= wd_q[0];
              rd_q <= wd_q[1];
              code_q <= wd_q[7:4];
            end
          end
          ADDR_OFS: addr_q <= wd_q[10:0];
          WDATA_OFS: wdat_q <= wd_q[7:0];
          STATUS_OFS: ;
          default: BRESP <= AXI_SLVERR;
        endcase
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end
  // read channel answers one cycle after the address
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= AXI_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= AXI_OKAY;
      unique case (ARADDR)
        CMD_OFS: RDATA <= {24'h0, code_q, 2'h0, rd_q, 1'b0};
        ADDR_OFS: RDATA <= {21'h0, addr_q};
        WDATA_OFS: RDATA <= {24'h0, wdat_q};
        STATUS_OFS: RDATA <= {22'h0, nack_q, busy_q, rdat_q};
        default: begin
          RDATA <= 32'h0;
          RRESP <= AXI_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end
  // ********************************
  // link sequencer: divided clock, bit frames
  // ********************************
  logic [4:0] div_q;
  logic scl_q;
  logic sda_q;
  lstate_type ls_q;
  logic [5:0] slot_q;
  logic [5:0] nslots_q;
  logic [39:0] frame_q;
  logic [39:0] ackm_q;
  logic [5:0] rstart_q;
  logic is_rs;
  logic is_stop;
  logic sda_s;
  sync2 u_sync (.clk(REF_CLK), .rst(SYS_RST), .din(LINK.data_line), .dout(sda_s));
  // slot kinds: repeated start, stop, otherwise one data or acknowledge bit
  assign is_rs = (slot_q == rstart_q);
  assign is_stop = (slot_q == nslots_q);
  // a slot: clock low at 0, data moves at a quarter, clock high at half,
  // start or stop edge at three quarters; data never moves with a clock edge
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      div_q <= 5'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ls_q <= L_IDLE;
      slot_q <= 6'h0;
      nslots_q <= 6'h0;
      frame_q <= 40'h0;
      ackm_q <= 40'h0;
      rstart_q <= 6'h0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      rdat_q <= 8'h00;
    end else if (ls_q == L_IDLE) begin
      div_q <= 5'h0;
      scl_q <= 1'b1;
      if (go_q) begin
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        ls_q <= L_START;
        sda_q <= 1'b0;
        // control, address, then data or repeated start plus read control
        frame_q <= {code_q, addr_q[10:8], DIR_WRITE, 1'b1, addr_q[7:0], 1'b1,
          rd_q ? {code_q, addr_q[10:8], DIR_READ} : wdat_q, 1'b1, 8'hff, 1'b1, 4'h0};
        ackm_q <= {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 13'h0};
        nslots_q <= rd_q ? 6'd37 : 6'd27;
        rstart_q <= rd_q ? 6'd18 : 6'd63;
        slot_q <= 6'h0;
      end
    end else begin
      div_q <= (div_q == 5'(2 * CLK_DIV - 1)) ? 5'h0 : div_q + 5'h1;
      // start hold: one slot with the clock still high
      if (ls_q == L_START && div_q == 5'(2 * CLK_DIV - 1)) ls_q <= L_BITS;
      if (ls_q == L_BITS) begin
        if (div_q == 5'h0) scl_q <= 1'b0;
        if (div_q == 5'(CLK_DIV / 2)) sda_q <= is_rs ? 1'b1 : (is_stop ? 1'b0 : frame_q[39]);
        if (div_q == 5'(CLK_DIV)) scl_q <= 1'b1;
        if (div_q == 5'(CLK_DIV + CLK_DIV / 2)) begin
          if (is_rs) sda_q <= 1'b0;
          if (is_stop) begin
            sda_q <= 1'b1;
            ls_q <= L_IDLE;
            busy_q <= 1'b0;
          end
        end
        // sample at the end of the high phase, then advance
        if (div_q == 5'(2 * CLK_DIV - 1)) begin
          slot_q <= slot_q + 6'h1;
          if (!is_rs) begin
            if (ackm_q[39] && sda_s) nack_q <= 1'b1;
            if (slot_q >= 6'd28 && slot_q < 6'd36) rdat_q <= {rdat_q[6:0], sda_s};
            frame_q <= {frame_q[38:0], 1'b1};
            ackm_q <= {ackm_q[38:0], 1'b0};
          end
        end
      end
    end
  end
  assign LINK.link_clk = scl_q;
  assign LINK.data_ctl_out = 1'b0;
  assign LINK.data_ctl_oe_n = sda_q;
endmodule // regctl_controller

// ===== tb/regctl_chk.sv
// wire-level checker for the two-wire register access link
`timescale 1ns/1ps
module regctl_chk #(parameter logic [3:0] EXP_CODE = 4'ha) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic link_clk,
  input wire logic data_ctl_oe_n,
  input wire logic data_tgt_oe_n,
  input wire logic data_line
);
  // ********************************
  // frame and bit position tracking
  // ********************************
  logic clk_q, dat_q, frame_q;
  logic [3:0] cnt_q;
  logic [1:0] byte_q;
  logic [7:0] cb_q;
  logic rise, start, stop, code_ok, rd_dir;
  // link clock is divided from REF_CLK, so sampling it here is exact
  assign rise = link_clk & ~clk_q;
  assign start = link_clk & clk_q & dat_q & ~data_line;
  assign stop = link_clk & clk_q & ~dat_q & data_line;
  assign code_ok = (cb_q[7:4] == EXP_CODE);
  assign rd_dir = cb_q[0];
  // previous levels for edge detection
  always_ff @(posedge REF_CLK) begin
    clk_q <= link_clk;
    dat_q <= data_line;
  end
  // inside a frame between start and stop
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || stop) frame_q <= 1'b0;
    else if (start) frame_q <= 1'b1;
  end
  // slot 8 is the acknowledge; stop adds a harmless extra rise
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || start) begin
      cnt_q <= 4'h0;
      byte_q <= 2'h0;
    end else if (rise) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h8 && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
    end
  end
  // first byte after each start is the control byte
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) cb_q <= 8'h00;
    else if (rise && cnt_q < 4'h8 && byte_q == 2'h0) cb_q <= {cb_q[6:0], data_line};
  end
  // ********************************
  // assertions
  // ********************************
  default clocking dclk @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_ctrl_ack;
    rise && cnt_q == 4'h8 && byte_q == 2'h0;
  endsequence
  sequence s_wr_ack;
    rise && cnt_q == 4'h8 && (byte_q == 2'h1 || byte_q == 2'h2) && !rd_dir;
  endsequence
  a_ack_ctrl_code: assert property (s_ctrl_ack ##0 code_ok |-> !data_line)
    else $error("control byte not acknowledged");
  a_nak_code_miss: assert property (s_ctrl_ack ##0 !code_ok |-> data_line)
    else $error("foreign control code acknowledged");
  a_ack_write_bytes: assert property (s_wr_ack ##0 code_ok |-> !data_line)
    else $error("address or data byte not acknowledged");
  a_ctl_off_ack: assert property (s_ctrl_ack |-> data_ctl_oe_n)
    else $error("controller drives the acknowledge slot");
  a_tgt_quiet_bits: assert property (rise && cnt_q < 4'h8 && !(byte_q == 2'h1 && rd_dir)
    |-> data_tgt_oe_n)
    else $error("target drives a controller bit");
  a_ctl_off_read: assert property (rise && cnt_q < 4'h8 && byte_q == 2'h1 && rd_dir
    |-> data_ctl_oe_n)
    else $error("controller drives read data");
  a_read_bit_hold: assert property (rise && cnt_q < 4'h8 && byte_q == 2'h1 && rd_dir
    |=> $stable(data_line) [*8])
    else $error("read bit changes while clock high");
  a_clk_idle_high: assert property (!frame_q |-> link_clk)
    else $error("link clock not idle high");
  a_tgt_idle: assert property (!frame_q |-> data_tgt_oe_n)
    else $error("target drives line outside frame");
endmodule // regctl_chk

// ===== tb/test_i2c_target_register_access.sv
// testbench: controller and target joined over the link, driven over axi4-lite
`timescale 1ns/1ps
module test_i2c_target_register_access import regctl_pkg::*;;
  localparam logic [3:0] CODE = 4'ha; // arbitrary configured control code
  localparam int TMO = 60000;
  logic ref_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, reg_out;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0] bresp, rresp, rsp;
  logic [10:0] ptrs [4] = '{11'h0f4, 11'h000, 11'h0ff, 11'h055};
  logic [7:0] vals [4] = '{8'h01, 8'h3c, 8'ha5, 8'h5a};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  regctl_link_if link();
  regctl_controller regctl_controller_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .LINK(link),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));
  regctl_target regctl_target_inst (.SYS_RST(sys_rst), .CTRL_CODE(CODE), .LINK(link),
    .REGULATOR_CONTROL_OUTPUT(reg_out));
  regctl_chk #(.EXP_CODE(CODE)) regctl_chk_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .link_clk(link.link_clk), .data_ctl_oe_n(link.data_ctl_oe_n),
    .data_tgt_oe_n(link.data_tgt_oe_n), .data_line(link.data_line));
  // ********************************
  // clock, watchdog and reporting
  // ********************************
  always #25 ref_clk = ~ref_clk;
  // cuts a hung handshake short; tests need roughly 13000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == TMO) begin
      n_errors++;
      $display("ERROR watchdog expected done seen %0d cycles", cycles);
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // ********************************
  // axi4-lite master tasks
  // ********************************
  // address and data offered together, each dropped once taken
  task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // one link command, then poll until the controller is idle again
  task xfer(input logic [3:0] code, input logic rd, input logic [10:0] ptr,
    input logic [7:0] d);
    axw(ADDR_OFS, {21'h0, ptr}, rsp);
    axw(WDATA_OFS, {24'h0, d}, rsp);
    axw(CMD_OFS, {24'h0, code, 2'b00, rd, 1'b1}, rsp);
    st = 32'h100;
    while (st[8] === 1'b1) axr(STATUS_OFS, st, rsp);
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    // two cycles; the target resets without its link clock
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axr(STATUS_OFS, st, rsp);
    chk("busy_after_reset", 32'h0, {31'h0, st[8]});
    chk("regulator_reset", {31'h0, REGULATOR_CONTROL_RESET[REGULATOR_BIT]}, {31'h0, reg_out});
    axr(4'h2, st, rsp);
    chk("unmapped_resp", {30'h0, AXI_SLVERR}, {30'h0, rsp});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      xfer(CODE, DIR_WRITE, ptrs[i], vals[i]);
      chk("write_nack", 32'h0, {31'h0, st[9]});
    end
    chk("regulator_on", 32'h1, {31'h0, reg_out});
    $display("test byte write done");
    for (int i = 0; i < 4; i++) begin
      xfer(CODE, DIR_READ, ptrs[i], 8'h00);
      chk("read_byte", {24'h0, vals[i]}, {24'h0, st[7:0]});
    end
    $display("test random read done");
    xfer(CODE ^ 4'h5, DIR_WRITE, REGULATOR_OUTPUT_CONTROL_OFS, 8'h00);
    chk("foreign_code_nack", 32'h1, {31'h0, st[9]});
    chk("regulator_kept", 32'h1, {31'h0, reg_out});
    xfer(CODE, DIR_READ, REGULATOR_OUTPUT_CONTROL_OFS, 8'h00);
    chk("byte_kept", 32'h01, {24'h0, st[7:0]});
    $display("test foreign code done");
    xfer(CODE, DIR_WRITE, REGULATOR_OUTPUT_CONTROL_OFS, 8'hfe);
    chk("regulator_off", 32'h0, {31'h0, reg_out});
    xfer(CODE, DIR_READ, REGULATOR_OUTPUT_CONTROL_OFS, 8'h00);
    chk("regulator_byte", 32'hfe, {24'h0, st[7:0]});
    $display("test regulator bit done");
    test_done();
  end
endmodule // test_i2c_target_register_access
